/* File: pdl_bank.v */
/*
  Power-down, lock detector and calibration divider configuration bank.
  Holds four 8-bit registers reached through the parallel register port
  of the serial control interface, and drives the gating and enable levels
  of the analog and digital sub-blocks.
  Assumes the control interface decoder presents single-cycle read and
  write strobes synchronous to i_clk, and that i_resetn is the power-on
  reset, asynchronous and active low.
*/
// Function
// - Main power-down resets set, keeps registers intact.
// - Every power-down bit: zero active, one off.
// - Reference divider and doubler off together.
// - Feedback divider off when set, else running.
// - Lock detection logic off when set.
// - Phase detector and charge pump off together.
// - Clock output buffer off, resets off.
// - Pulse output buffer off, resets off.
// - Calibration converter off when set, resets active.
// - Loss-of-lock detection enabled by one, resets disabled.
// - Window width select: zero narrow, one wide.
// - Lock pulse window enabled by one.
// - Five-bit count of valid cycles before lock.
// - Lock clear holds unlocked until software clears.
`include "pdl_consts.vh"
`default_nettype none

module pdl_bank (
  // Clock and reset.
  input  wire       i_clk,
  input  wire       i_resetn,
  // Register port from the control interface.
  input  wire       i_write,
  input  wire       i_read,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  output reg  [7:0] o_rdata,
  output reg        o_rvalid,
  output reg        o_rhit,
  // Main power-down level.
  output wire       o_main_power_off,
  // Effective block power-down levels.
  output wire       o_ref_divider_off,
  output wire       o_doubler_off,
  output wire       o_feedback_divider_off,
  output wire       o_oscillator_off,
  output wire       o_lock_detector_off,
  output wire       o_phase_detector_off,
  output wire       o_charge_pump_off,
  output wire       o_clock_buffer_off,
  output wire       o_pulse_buffer_off,
  // Auxiliary power-down levels.
  output wire       o_cal_converter_off,
  output wire       o_temp_converter_off,
  output wire       o_ref_detector_off,
  output wire       o_clock_divider_off,
  output wire [1:0] o_clock_amplitude,
  // Lock detector configuration.
  output wire       o_loss_of_lock_enable,
  output wire       o_lock_window_wide,
  output wire       o_lock_window_enable,
  output wire [4:0] o_lock_valid_cycles,
  output wire       o_lock_detector_clear,
  // Calibration divider enables.
  output wire       o_cal_feedback_div_enable,
  output wire       o_cal_ref_div_enable
);

  // Register contents.
  wire [7:0] aux_power_down;
  wire [7:0] block_power_down;
  wire [7:0] lock_detect_config;
  wire [7:0] cal_divider_and_lock_reset;

  // Decoded write strobes.
  wire       wr_aux;
  wire       wr_block;
  wire       wr_lock;
  wire       wr_cal;

  // Read multiplexer.
  reg  [7:0] next_rdata;
  reg        next_rhit;

  // Effective power-down vector from the gate.
  wire [7:0] gated_off;
  wire [7:0] individual_off;

  // Address decode of the write strobe; other offsets are ignored.
  assign wr_aux   = i_write && (i_addr == `PDL_ADDR_AUX_POWER_DOWN);
  assign wr_block = i_write && (i_addr == `PDL_ADDR_BLOCK_POWER_DOWN);
  assign wr_lock  = i_write && (i_addr == `PDL_ADDR_LOCK_DETECT_CFG);
  assign wr_cal   = i_write && (i_addr == `PDL_ADDR_CAL_DIV_LOCK_RST);

  // Auxiliary power-down register, reference detector starts off.
  pdl_reg8 #(
    .RESET_VALUE (`PDL_RST_AUX_POWER_DOWN)
  ) u_aux (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_write  (wr_aux),
    .i_wdata  (i_wdata),
    .o_value  (aux_power_down)
  );

  // Block power-down register, main and both output buffers start off.
  pdl_reg8 #(
    .RESET_VALUE (`PDL_RST_BLOCK_POWER_DOWN)
  ) u_block (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_write  (wr_block),
    .i_wdata  (i_wdata),
    .o_value  (block_power_down)
  );

  // Lock detector configuration register.
  pdl_reg8 #(
    .RESET_VALUE (`PDL_RST_LOCK_DETECT_CFG)
  ) u_lock (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_write  (wr_lock),
    .i_wdata  (i_wdata),
    .o_value  (lock_detect_config)
  );

  // Calibration divider enables and lock detector clear.
  pdl_reg8 #(
    .RESET_VALUE (`PDL_RST_CAL_DIV_LOCK_RST)
  ) u_cal (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_write  (wr_cal),
    .i_wdata  (i_wdata),
    .o_value  (cal_divider_and_lock_reset)
  );

  // Individual bits; bit 7 slot carries the main bit itself.
  assign individual_off = block_power_down;

  // The main power-down is a gate only; it never touches register contents.
  pdl_gate #(
    .WIDTH       (8),
    .RESET_VALUE ({8'h00, `PDL_RST_BLOCK_POWER_DOWN | 8'h7f})
  ) u_gate (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_main_off (block_power_down[`PDL_BPD_MAIN_POWER_OFF]),
    .i_bits_off (individual_off),
    .o_off      (gated_off)
  );

  // Main power-down level as programmed.
  assign o_main_power_off       = gated_off[`PDL_BPD_MAIN_POWER_OFF];

  // Reference divider and doubler share one bit.
  assign o_ref_divider_off      = gated_off[`PDL_BPD_REF_DIVIDER_OFF];
  assign o_doubler_off          = gated_off[`PDL_BPD_REF_DIVIDER_OFF];

  // Feedback divider runs while its bit and the main bit are clear.
  assign o_feedback_divider_off = gated_off[`PDL_BPD_FEEDBACK_DIV_OFF];

  // Oscillator uses the same one-means-off polarity.
  assign o_oscillator_off       = gated_off[`PDL_BPD_OSCILLATOR_OFF];

  // Lock detection logic.
  assign o_lock_detector_off    = gated_off[`PDL_BPD_LOCK_DETECTOR_OFF];

  // Phase detector and charge pump share one bit.
  assign o_phase_detector_off   = gated_off[`PDL_BPD_PHASE_PUMP_OFF];
  assign o_charge_pump_off      = gated_off[`PDL_BPD_PHASE_PUMP_OFF];

  // Output buffers, both off from power-on.
  assign o_clock_buffer_off     = gated_off[`PDL_BPD_CLOCK_BUFFER_OFF];
  assign o_pulse_buffer_off     = gated_off[`PDL_BPD_PULSE_BUFFER_OFF];

  // Auxiliary power-down levels straight from their flip-flops.
  assign o_cal_converter_off    = aux_power_down[`PDL_AUX_CAL_CONVERTER_OFF];
  assign o_temp_converter_off   = aux_power_down[`PDL_AUX_TEMP_CONV_OFF];
  assign o_ref_detector_off     = aux_power_down[`PDL_AUX_REF_DETECT_OFF];
  assign o_clock_divider_off    = aux_power_down[`PDL_AUX_CLK_DIV_OFF];
  assign o_clock_amplitude      = aux_power_down[`PDL_AUX_AMP_HI:`PDL_AUX_AMP_LO];

  // Lock detector configuration fields.
  assign o_loss_of_lock_enable  = lock_detect_config[`PDL_LDC_LOSS_OF_LOCK_EN];
  assign o_lock_window_wide     = lock_detect_config[`PDL_LDC_WINDOW_WIDE];
  assign o_lock_window_enable   = lock_detect_config[`PDL_LDC_WINDOW_ENABLE];
  assign o_lock_valid_cycles    =
    lock_detect_config[`PDL_LDC_VALID_CYCLES_HI:`PDL_LDC_VALID_CYCLES_LO];

  // Lock clear stays set until software writes it to zero.
  assign o_lock_detector_clear  = cal_divider_and_lock_reset[`PDL_CDL_LOCK_CLEAR];

  // Calibration divider enables are plain levels that software brackets.
  assign o_cal_feedback_div_enable =
    cal_divider_and_lock_reset[`PDL_CDL_FEEDBACK_DIV_EN];
  assign o_cal_ref_div_enable      =
    cal_divider_and_lock_reset[`PDL_CDL_REF_DIV_EN];

  // Read multiplexer returns every stored bit, reserved ones included.
  always @*
  begin
    next_rdata = 8'h00;
    next_rhit  = 1'b1;
    case (i_addr)
      `PDL_ADDR_AUX_POWER_DOWN:   next_rdata = aux_power_down;
      `PDL_ADDR_BLOCK_POWER_DOWN: next_rdata = block_power_down;
      `PDL_ADDR_LOCK_DETECT_CFG:  next_rdata = lock_detect_config;
      `PDL_ADDR_CAL_DIV_LOCK_RST: next_rdata = cal_divider_and_lock_reset;
      default:
      begin
        next_rdata = 8'h00;
        next_rhit  = 1'b0;
      end
    endcase
  end

  // Read data is captured one cycle after the strobe and held until the next read.
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rdata  <= 8'h00;
      o_rvalid <= 1'b0;
      o_rhit   <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_read;
      if (i_read)
      begin
        o_rdata <= next_rdata;
        o_rhit  <= next_rhit;
      end
    end
  end

endmodule

`default_nettype wire

/* File: pdl_bank_chk.sv */
/*
  Port checker for the power-down and lock-detect register bank.
  Assumes it is bound into pdl_bank, with one clock and an active-low reset.
*/
`default_nettype none
module pdl_bank_chk (
  // Clock, reset and register port.
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic       i_write,
  input wire logic       i_read,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic       o_rvalid,
  input wire logic       o_rhit,
  // Watched configuration levels.
  input wire logic       o_main_power_off,
  input wire logic       o_ref_divider_off,
  input wire logic       o_doubler_off,
  input wire logic       o_phase_detector_off,
  input wire logic       o_charge_pump_off,
  input wire logic       o_pulse_buffer_off,
  input wire logic       o_cal_converter_off,
  input wire logic       o_loss_of_lock_enable,
  input wire logic [4:0] o_lock_valid_cycles,
  input wire logic       o_lock_detector_clear,
  input wire logic       o_cal_ref_div_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic map_a;
  logic wr_bpd;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // Address decode seen from outside the bank.
  assign map_a = (i_addr >= 8'h19) && (i_addr <= 8'h1c);
  assign wr_bpd = i_write && (i_addr == 8'h1a);

  // Read answers arrive exactly one cycle after the request.
  a_read_answer: assert property (i_read |=> o_rvalid)
    else $error("read answer missing");
  a_no_spurious: assert property (!i_read |=> !o_rvalid)
    else $error("read answer without request");
  a_unmapped_read: assert property (i_read && !map_a |=> !o_rhit && o_rdata == 8'h00)
    else $error("unmapped read not refused");
  a_rdata_hold: assert property (!i_read |=> $stable(o_rdata) && $stable(o_rhit))
    else $error("read data moved without read");
  // Main power-down forces the reference divider, doubler, phase detector, charge pump and pulse buffer off.
  property p_main_forces;
    o_main_power_off |-> o_ref_divider_off && o_charge_pump_off
      && o_pulse_buffer_off && o_phase_detector_off && o_doubler_off;
  endproperty
  a_main_forces: assert property (p_main_forces)
    else $error("block active under main power-down");

  // Shared gating bits follow the write two edges later.
  property p_ref_pair;
    wr_bpd |=> ##1 o_ref_divider_off == o_doubler_off
      && o_doubler_off == ($past(i_wdata[6], 2) | $past(i_wdata[7], 2));
  endproperty
  a_ref_pair: assert property (p_ref_pair)
    else $error("reference divider gating wrong");
  property p_pump_pair;
    wr_bpd |=> ##1 o_charge_pump_off == o_phase_detector_off
      && o_charge_pump_off == ($past(i_wdata[2], 2) | $past(i_wdata[7], 2));
  endproperty
  a_pump_pair: assert property (p_pump_pair)
    else $error("phase detector gating wrong");

  // Direct register levels follow the write one edge later.
  property p_aux_write;
    i_write && i_addr == 8'h19 |=> o_cal_converter_off == $past(i_wdata[0]);
  endproperty
  a_aux_write: assert property (p_aux_write)
    else $error("converter power-down not written");
  property p_lock_cfg;
    i_write && i_addr == 8'h1b |=> {o_loss_of_lock_enable, o_lock_valid_cycles}
      == {$past(i_wdata[7]), $past(i_wdata[4:0])};
  endproperty
  a_lock_cfg: assert property (p_lock_cfg)
    else $error("lock configuration not written");
  property p_clear_sticky;
    o_lock_detector_clear && !(i_write && i_addr == 8'h1c) |=> o_lock_detector_clear;
  endproperty
  a_clear_sticky: assert property (p_clear_sticky)
    else $error("lock clear dropped by itself");
  property p_cal_write;
    i_write && i_addr == 8'h1c |=> o_cal_ref_div_enable == $past(i_wdata[6]);
  endproperty
  a_cal_write: assert property (p_cal_write)
    else $error("calibration divider enable not written");

  // Main scenarios reached.
  c_unmapped: cover property (i_read && !map_a);
  c_main_off: cover property (wr_bpd && i_wdata[7]);
  c_clear_hold: cover property (o_lock_detector_clear [*8]);
endmodule

bind pdl_bank pdl_bank_chk u_chk (.i_clk, .i_resetn, .i_write, .i_read, .i_addr, .i_wdata,
  .o_rdata, .o_rvalid, .o_rhit, .o_main_power_off, .o_ref_divider_off, .o_doubler_off,
  .o_phase_detector_off, .o_charge_pump_off, .o_pulse_buffer_off, .o_cal_converter_off,
  .o_loss_of_lock_enable, .o_lock_valid_cycles, .o_lock_detector_clear, .o_cal_ref_div_enable);
`default_nettype wire

/* File: pdl_consts.vh */
/*
  Constants of the power-down and lock-detect register bank: offsets, reset
  values and field positions. Assumes it is included by bare name by the bank
  alone, not by its helper modules; definitions only.
*/
`ifndef PDL_CONSTS_VH
`define PDL_CONSTS_VH

// Register offsets on the control interface.
`define PDL_ADDR_AUX_POWER_DOWN    8'h19
`define PDL_ADDR_BLOCK_POWER_DOWN  8'h1a
`define PDL_ADDR_LOCK_DETECT_CFG   8'h1b
`define PDL_ADDR_CAL_DIV_LOCK_RST  8'h1c

// Power-on reset values.
`define PDL_RST_AUX_POWER_DOWN     8'h04
`define PDL_RST_BLOCK_POWER_DOWN   8'h83
`define PDL_RST_LOCK_DETECT_CFG    8'h00
`define PDL_RST_CAL_DIV_LOCK_RST   8'h00

// Auxiliary power-down register fields.
`define PDL_AUX_RSV_HI             7
`define PDL_AUX_RSV_LO             6
`define PDL_AUX_AMP_HI             5
`define PDL_AUX_AMP_LO             4
`define PDL_AUX_CLK_DIV_OFF        3
`define PDL_AUX_REF_DETECT_OFF     2
`define PDL_AUX_TEMP_CONV_OFF      1
`define PDL_AUX_CAL_CONVERTER_OFF  0

// Block power-down register fields.
`define PDL_BPD_MAIN_POWER_OFF     7
`define PDL_BPD_REF_DIVIDER_OFF    6
`define PDL_BPD_FEEDBACK_DIV_OFF   5
`define PDL_BPD_OSCILLATOR_OFF     4
`define PDL_BPD_LOCK_DETECTOR_OFF  3
`define PDL_BPD_PHASE_PUMP_OFF     2
`define PDL_BPD_CLOCK_BUFFER_OFF   1
`define PDL_BPD_PULSE_BUFFER_OFF   0

// Lock detector configuration fields.
`define PDL_LDC_LOSS_OF_LOCK_EN    7
`define PDL_LDC_WINDOW_WIDE        6
`define PDL_LDC_WINDOW_ENABLE      5
`define PDL_LDC_VALID_CYCLES_HI    4
`define PDL_LDC_VALID_CYCLES_LO    0

// Calibration divider and lock reset fields.
`define PDL_CDL_FEEDBACK_DIV_EN    7
`define PDL_CDL_REF_DIV_EN         6
`define PDL_CDL_RSV4               5
`define PDL_CDL_RSV3               4
`define PDL_CDL_RSV2               3
`define PDL_CDL_LOCK_CLEAR         2
`define PDL_CDL_RSV1_HI            1
`define PDL_CDL_RSV1_LO            0

`endif

/* File: pdl_gate.v */
/*
  Registered gating of individual power-down bits by the main power-down.
  Assumes the inputs come straight from register flip-flops on i_clk.
*/
`default_nettype none

module pdl_gate #(
  parameter        WIDTH       = 8,
  parameter [15:0] RESET_VALUE = 16'hffff
) (
  // Clock and reset.
  input  wire             i_clk,
  input  wire             i_resetn,
  // Main power-down and individual bits.
  input  wire             i_main_off,
  input  wire [WIDTH-1:0] i_bits_off,
  // Effective power-down levels.
  output wire [WIDTH-1:0] o_off
);

  genvar g;

  // Each block is off when its own bit or the main power-down is set.
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : gen_gate
      reg off_q;
      always @(posedge i_clk or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          off_q <= RESET_VALUE[g];
        end
        else
        begin
          off_q <= i_bits_off[g] | i_main_off;
        end
      end
      assign o_off[g] = off_q;
    end
  endgenerate

endmodule

`default_nettype wire

/* File: pdl_reg8.v */
/*
  One 8-bit read/write configuration register with a power-on value.
  Assumes the write strobe is already decoded for this register and is
  synchronous to i_clk.
*/
`default_nettype none

module pdl_reg8 #(
  parameter [7:0] RESET_VALUE = 8'h00
) (
  // Clock and reset.
  input  wire       i_clk,
  input  wire       i_resetn,
  // Write side.
  input  wire       i_write,
  input  wire [7:0] i_wdata,
  // Stored value.
  output reg  [7:0] o_value
);

  // Only the power-on reset or a write changes the stored value.
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_value <= RESET_VALUE;
    end
    else if (i_write)
    begin
      o_value <= i_wdata;
    end
  end

endmodule

`default_nettype wire

/* File: tb_pdl_bank.sv */
/*
  Self-checking bench for the power-down and lock-detect register bank.
  Assumes pdl_bank and its bound checker are compiled alongside.
*/
`default_nettype none
module tb_pdl_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic            i_clk = 1'b0;
  logic            i_resetn = 1'b0;
  logic            i_write = 1'b0;
  logic            i_read = 1'b0;
  logic [7:0]      i_addr = 8'h00;
  logic [7:0]      i_wdata = 8'h00;
  wire logic [7:0] o_rdata;
  wire logic       o_rvalid;
  wire logic       o_rhit;
  wire logic [7:0] gated;
  wire logic [5:0] aux;
  wire logic [7:0] ldc;
  wire logic [2:0] cdl;
  wire logic       doub;
  wire logic       pump;
  logic [7:0]      mdl [4];
  logic [8:0]      expq [$];
  int              error_cnt = 0;
  int              comparisons = 0;
  int              cycles = 0;

  pdl_bank uut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_write(i_write), .i_read(i_read),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_rhit(o_rhit), .o_main_power_off(gated[7]), .o_ref_divider_off(gated[6]),
    .o_doubler_off(doub), .o_feedback_divider_off(gated[5]), .o_oscillator_off(gated[4]),
    .o_lock_detector_off(gated[3]), .o_phase_detector_off(gated[2]), .o_charge_pump_off(pump),
    .o_clock_buffer_off(gated[1]), .o_pulse_buffer_off(gated[0]),
    .o_cal_converter_off(aux[0]), .o_temp_converter_off(aux[1]), .o_ref_detector_off(aux[2]),
    .o_clock_divider_off(aux[3]), .o_clock_amplitude(aux[5:4]),
    .o_loss_of_lock_enable(ldc[7]), .o_lock_window_wide(ldc[6]),
    .o_lock_window_enable(ldc[5]), .o_lock_valid_cycles(ldc[4:0]),
    .o_lock_detector_clear(cdl[0]), .o_cal_feedback_div_enable(cdl[2]),
    .o_cal_ref_div_enable(cdl[1])
  );

  // Free-running 25 MHz clock.
  always #20 i_clk = ~i_clk;

  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One write strobe; the model follows only mapped offsets.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_write <= 1'b0;
    if (a >= 8'h19 && a <= 8'h1c) mdl[a - 8'h19] = d;
  endtask

  // Reads every offset around the bank and notes each expected answer.
  task automatic rd_all();
    for (int a = 8'h18; a <= 8'h1d; a++)
    begin
      @(posedge i_clk);
      i_read <= 1'b1;
      i_addr <= 8'(a);
      if (a >= 8'h19 && a <= 8'h1c) expq.push_back({1'b1, mdl[a - 8'h19]});
      else expq.push_back(9'h000);
      @(posedge i_clk);
      i_read <= 1'b0;
    end
    repeat (3) @(posedge i_clk);
  endtask

  // Compares every level output once the gated copies have settled.
  task automatic chk_outs();
    logic [7:0] e;
    repeat (2) @(posedge i_clk);
    #1;
    e = mdl[1][7] ? 8'hff : mdl[1];
    chk({1'b0, gated}, {1'b0, e});
    chk({7'h0, doub, pump}, {7'h0, e[6], e[2]});
    chk({3'h0, aux}, {3'h0, mdl[0][5:0]});
    chk({1'b0, ldc}, {1'b0, mdl[2]});
    chk({6'h0, cdl}, {6'h0, mdl[3][7:6], mdl[3][2]});
  endtask

  // Holds reset for ten edges and loads the power-on model.
  task automatic rst();
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    mdl = '{8'h04, 8'h83, 8'h00, 8'h00};
  endtask

  // Read answers are matched in order against the noted expectations.
  always @(posedge i_clk)
  begin
    if (o_rvalid === 1'b1 && expq.size() == 0) chk(9'h1ff, 9'h000);
    else if (o_rvalid === 1'b1) chk({o_rhit, o_rdata}, expq.pop_front());
  end

  // Cuts a hung run short.
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      results();
    end
  end

  // Main sequence.
  initial
  begin
    void'($urandom(32'h0424));
    rst();
    chk_outs();
    rd_all();
    $display("test reset_defaults done");
    repeat (4)
    begin
      for (int a = 8'h19; a <= 8'h1c; a++) wr(8'(a), 8'($urandom()));
      chk_outs();
      rd_all();
    end
    $display("test random_readback done");
    wr(8'h1b, 8'h3c);
    wr(8'h1c, 8'hc3);
    wr(8'h1a, 8'h00);
    chk_outs();
    for (int b = 0; b < 8; b++)
    begin
      wr(8'h1a, 8'h01 << b);
      chk_outs();
    end
    wr(8'h1d, 8'hff);
    wr(8'h18, 8'hff);
    rd_all();
    $display("test power_down_bits done");
    wr(8'h1c, 8'h04);
    repeat (40) @(posedge i_clk);
    chk_outs();
    wr(8'h1c, 8'h00);
    chk_outs();
    $display("test lock_clear done");
    wr(8'h1c, 8'hc0);
    chk_outs();
    wr(8'h1c, 8'h00);
    chk_outs();
    $display("test cal_bracket done");
    for (int a = 8'h19; a <= 8'h1c; a++) wr(8'(a), 8'hff);
    rst();
    chk_outs();
    rd_all();
    $display("test second_reset done");
    chk(9'(expq.size()), 9'h000);
    results();
  end
endmodule
`default_nettype wire
